// >>> rtl/control_mode_switch_router.v
// control mode selection and analog terminal routing with ahb-lite registers
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`include "mode_router_consts.vh"

module control_mode_switch_router #(
	parameter N_TERM = 12
) (
	input  wire               mclk,
	input  wire               rst_b,
	input  wire               hsel,
	input  wire [31:0]        haddr,
	input  wire [1:0]         htrans,
	input  wire               hwrite,
	input  wire [2:0]         hsize,
	input  wire [31:0]        hwdata,
	input  wire               hready,
	output reg  [31:0]        hrdata,
	output reg                hreadyout,
	output reg                hresp,
	input  wire [N_TERM-1:0]  input_terminals,
	input  wire               analog_select_input,
	input  wire               motor_running,
	output reg  [1:0]         active_mode,
	output reg  [3:0]         terminal1_function,
	output reg  [3:0]         terminal4_function,
	output reg                mode_change_pending
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg  [3:0]        control_method_setting;
	reg  [13:0]       terminal1_assignment;
	reg  [13:0]       terminal4_assignment;
	reg  [1:0]        torque_limit_input_method;
	reg  [1:0]        torque_command_source;
	reg  [1:0]        speed_limit_selection;
	reg  [15:0]       low_speed_threshold;
	reg  [15:0]       output_frequency;
	reg  [8*N_TERM-1:0] input_terminal_function_select;

	// ------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ------------------------------------------------------------
	reg               wr_pend;
	reg  [7:0]        wr_addr;
	wire              take = hsel & hready & htrans[1];
	wire [7:0]        wr_off = wr_addr - `ADDR_TERM_BASE;
	wire [7:0]        rd_off = haddr[7:0] - `ADDR_TERM_BASE;
	// terminal select words sit above the fixed registers, one word each
	wire              wr_term = (wr_addr >= `ADDR_TERM_BASE) && (wr_off[1:0] == 2'h0) &&
	                            (wr_off[7:2] < N_TERM);
	wire              rd_term = (haddr[7:0] >= `ADDR_TERM_BASE) && (rd_off[1:0] == 2'h0) &&
	                            (rd_off[7:2] < N_TERM);
	// hreadyout and hresp never move: every access ends at once
	// writes land one edge after the address phase, with hwdata

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend                        <= 1'b0;
			wr_addr                        <= 8'h00;
			hreadyout                      <= 1'b1;
			hresp                          <= 1'b0;
			control_method_setting         <= `RST_METHOD;
			terminal1_assignment           <= `RST_ASSIGN;
			terminal4_assignment           <= `RST_ASSIGN;
			torque_limit_input_method      <= 2'h0;
			torque_command_source          <= 2'h0;
			speed_limit_selection          <= 2'h0;
			low_speed_threshold            <= `RST_THRESHOLD;
			output_frequency               <= 16'h0000;
			input_terminal_function_select <= {(8*N_TERM){1'b0}};
		end else begin
			wr_pend <= take & hwrite;
			wr_addr <= haddr[7:0];
			if (wr_pend) begin
				case (wr_addr)
				`ADDR_METHOD:    control_method_setting <= hwdata[3:0];
				`ADDR_TERM1:     terminal1_assignment <= hwdata[13:0];
				`ADDR_TERM4:     terminal4_assignment <= hwdata[13:0];
				`ADDR_SOURCES: begin
					torque_limit_input_method <= hwdata[1:0];
					torque_command_source     <= hwdata[5:4];
					speed_limit_selection     <= hwdata[9:8];
				end
				`ADDR_THRESHOLD: low_speed_threshold <= hwdata[15:0];
				`ADDR_FREQ:      output_frequency <= hwdata[15:0];
				default: begin
					if (wr_term)
						input_terminal_function_select[8*wr_off[7:2] +: 8] <= hwdata[7:0];
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// input synchronisers, three stages, agreement of last two
	// ------------------------------------------------------------
	reg  [2:0]        term_sync [0:N_TERM-1];
	reg  [N_TERM-1:0] term_level;
	// a bouncing pin counts only once two stages agree
	// the cost is four cycles from pin to level on every input
	reg  [2:0]        sel_sync;
	reg               sel_level;
	genvar g;
	generate
		for (g = 0; g < N_TERM; g = g + 1) begin : sync
			always @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					term_sync[g]  <= 3'h0;
					term_level[g] <= 1'b0;
				end else begin
					term_sync[g] <= {term_sync[g][1:0], input_terminals[g]};
					if (term_sync[g][1] == term_sync[g][2])
						term_level[g] <= term_sync[g][2];
				end
			end
		end
	endgenerate

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sel_sync  <= 3'h0;
			sel_level <= 1'b0;
		end else begin
			sel_sync <= {sel_sync[1:0], analog_select_input};
			if (sel_sync[1] == sel_sync[2])
				sel_level <= sel_sync[2];
		end
	end

	// ------------------------------------------------------------
	// mode selection
	// ------------------------------------------------------------
	reg               mode_switch_input;
	reg  [1:0]        want_mode;
	reg  [1:0]        next_mode;
	integer           j;

	// several terminals coded for the mode input are ored
	always @* begin
		mode_switch_input = 1'b0;
		for (j = 0; j < N_TERM; j = j + 1) begin
			if (input_terminal_function_select[8*j +: 8] == `FUNC_CODE_MODE)
				mode_switch_input = mode_switch_input | term_level[j];
		end
	end

	// unknown codes fall back to speed, the safest fixed mode
	// fixed settings ignore the mode input entirely
	always @* begin
		case (control_method_setting)
		`METHOD_SPEED, `METHOD_SL_SPD: want_mode = `MODE_SPEED;
		`METHOD_TORQUE, `METHOD_SL_TRQ: want_mode = `MODE_TORQUE;
		`METHOD_POSITION: want_mode = `MODE_POSITION;
		`METHOD_SPD_TRQ, `METHOD_SL_SWT:
			want_mode = mode_switch_input ? `MODE_TORQUE : `MODE_SPEED;
		`METHOD_SPD_POS:
			want_mode = mode_switch_input ? `MODE_POSITION : `MODE_SPEED;
		`METHOD_POS_TRQ:
			want_mode = mode_switch_input ? `MODE_TORQUE : `MODE_POSITION;
		default: want_mode = `MODE_SPEED;
		endcase
	end

	// position changes while running wait for the low speed point
	// strict compare: a frequency equal to the threshold releases it
	wire involves_pos = (want_mode == `MODE_POSITION) || (active_mode == `MODE_POSITION);
	wire hold_change  = involves_pos && motor_running &&
	                    (output_frequency > low_speed_threshold);

	always @* begin
		if (want_mode != active_mode && hold_change)
			next_mode = active_mode;
		else
			next_mode = want_mode;
	end

	// ------------------------------------------------------------
	// terminal routing
	// ------------------------------------------------------------
	// routing follows next_mode so functions and mode move together
	// otherwise one cycle would pair the new mode with old functions
	reg  [3:0]        next_t1;
	reg  [3:0]        next_t4;
	wire              lim_ext = (torque_limit_input_method == 2'd1);
	wire              trq_src = (torque_command_source == 2'd0);
	wire              spd_lim = (speed_limit_selection == 2'd2);
	wire              m_spd   = (next_mode == `MODE_SPEED);
	wire              m_trq   = (next_mode == `MODE_TORQUE);
	wire              m_5     = (control_method_setting == `METHOD_POS_TRQ);
	wire              m_4     = (control_method_setting == `METHOD_SPD_POS);

	always @* begin
		next_t1 = `FN_NONE;
		case (terminal1_assignment)
		14'd0: begin
			if (m_spd)
				next_t1 = `FN_SPEED_AUX;
			else if (m_trq)
				next_t1 = m_5 ? `FN_SPEED_AUX : `FN_SPEED_LIMAUX;
		end
		14'd1: next_t1 = `FN_FLUX;
		14'd2: if (!m_trq && lim_ext) next_t1 = `FN_REGEN_LIMIT;
		14'd3: if (m_trq && trq_src) next_t1 = `FN_TORQUE_CMD;
		14'd4: begin
			if (m_trq) begin
				if (trq_src)
					next_t1 = `FN_TORQUE_CMD;
			end else if (lim_ext)
				next_t1 = `FN_TORQUE_LIMIT;
		end
		14'd5: if (m_trq && spd_lim) next_t1 = `FN_FWDREV_LIMIT;
		14'd6: if (m_spd && m_4) next_t1 = `FN_TORQUE_BIAS;
		default: next_t1 = `FN_NONE;
		endcase
	end

	always @* begin
		next_t4 = `FN_NONE;
		case (terminal4_assignment)
		14'd0: begin
			if (m_spd && sel_level)
				next_t4 = `FN_SPEED_CMD;
			else if (m_trq && sel_level)
				next_t4 = `FN_SPEED_LIMIT;
		end
		14'd1: next_t4 = `FN_FLUX;
		14'd4: if (!m_trq && lim_ext) next_t4 = `FN_TORQUE_LIMIT;
		default: next_t4 = `FN_NONE;
		endcase
	end

	// ------------------------------------------------------------
	// registered outputs, applied next cycle
	// ------------------------------------------------------------
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			active_mode         <= `MODE_SPEED;
			terminal1_function  <= `FN_NONE;
			terminal4_function  <= `FN_NONE;
			mode_change_pending <= 1'b0;
		end else begin
			active_mode         <= next_mode;
			terminal1_function  <= next_t1;
			terminal4_function  <= next_t4;
			// pending shows a wanted mode that the low speed rule holds back
			mode_change_pending <= (want_mode != next_mode);
		end
	end

	// ------------------------------------------------------------
	// read data, registered at the end of the address phase
	// ------------------------------------------------------------
	// hrdata is loaded in the address phase and stands through the data phase
	reg  [31:0]       rd_mux;
	always @* begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
		`ADDR_METHOD:    rd_mux = {28'h0, control_method_setting};
		`ADDR_TERM1:     rd_mux = {18'h0, terminal1_assignment};
		`ADDR_TERM4:     rd_mux = {18'h0, terminal4_assignment};
		`ADDR_SOURCES:   rd_mux = {22'h0, speed_limit_selection, 2'h0,
		                           torque_command_source, 2'h0, torque_limit_input_method};
		`ADDR_THRESHOLD: rd_mux = {16'h0, low_speed_threshold};
		`ADDR_FREQ:      rd_mux = {16'h0, output_frequency};
		`ADDR_STATUS:    rd_mux = {16'h0, 3'h0, mode_change_pending, terminal4_function,
		                           terminal1_function, 2'h0, active_mode};
		default: begin
			if (rd_term)
				rd_mux = {24'h0, input_terminal_function_select[8*rd_off[7:2] +: 8]};
		end
		endcase
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			hrdata <= 32'h00000000;
		else if (take && !hwrite)
			hrdata <= rd_mux;
	end

endmodule

// >>> common/mode_router_consts.vh
// constants for the control mode switch and analog terminal router
`ifndef MODE_ROUTER_CONSTS_VH
`define MODE_ROUTER_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ADDR_METHOD     8'h00
`define ADDR_TERM1      8'h04
`define ADDR_TERM4      8'h08
`define ADDR_SOURCES    8'h0c
`define ADDR_THRESHOLD  8'h10
`define ADDR_FREQ       8'h14
`define ADDR_STATUS     8'h18
`define ADDR_TERM_BASE  8'h20

// ------------------------------------------------------------
// control method codes
// ------------------------------------------------------------
`define METHOD_SPEED    4'd0
`define METHOD_TORQUE   4'd1
`define METHOD_SPD_TRQ  4'd2
`define METHOD_POSITION 4'd3
`define METHOD_SPD_POS  4'd4
`define METHOD_POS_TRQ  4'd5
`define METHOD_SL_SPD   4'd10
`define METHOD_SL_TRQ   4'd11
`define METHOD_SL_SWT   4'd12

// ------------------------------------------------------------
// active modes
// ------------------------------------------------------------
`define MODE_SPEED      2'd0
`define MODE_TORQUE     2'd1
`define MODE_POSITION   2'd2

// ------------------------------------------------------------
// terminal assignment codes
// ------------------------------------------------------------
`define ASSIGN_NONE     14'd9999
`define FUNC_CODE_MODE  8'd26

// ------------------------------------------------------------
// routed function codes
// ------------------------------------------------------------
`define FN_NONE         4'd0
`define FN_SPEED_AUX    4'd1
`define FN_SPEED_LIMAUX 4'd2
`define FN_FLUX         4'd3
`define FN_REGEN_LIMIT  4'd4
`define FN_TORQUE_CMD   4'd5
`define FN_TORQUE_LIMIT 4'd6
`define FN_FWDREV_LIMIT 4'd7
`define FN_TORQUE_BIAS  4'd8
`define FN_SPEED_CMD    4'd9
`define FN_SPEED_LIMIT  4'd10

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_METHOD      4'd0
`define RST_ASSIGN      14'd0
`define RST_THRESHOLD   16'd150

`endif

// >>> tb/mode_router_chk.sv
// checker on the routed function and mode outputs
`include "mode_router_consts.vh"
module mode_router_chk (
	input wire       mclk,
	input wire       rst_b,
	input wire [1:0] active_mode,
	input wire [3:0] terminal1_function,
	input wire [3:0] terminal4_function
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	wire spd = active_mode == `MODE_SPEED;
	wire trq = active_mode == `MODE_TORQUE;
	wire pos = active_mode == `MODE_POSITION;
	// ----------------
	// output relations
	// ----------------
	mode_code_a: assert property (active_mode != 2'h3)
		else $error("mode code out of range");
	pos_t1_a: assert property (pos |-> terminal1_function inside {0, 3, 4, 6})
		else $error("terminal 1 function illegal in position");
	trq_t1_a: assert property (trq |-> !(terminal1_function inside {4, 6, 8}))
		else $error("terminal 1 limit or bias in torque");
	spd_t1_a: assert property (spd |-> !(terminal1_function inside {2, 5, 7}))
		else $error("terminal 1 torque function in speed");
	bias_speed_a: assert property (terminal1_function == 4'h8 |-> spd)
		else $error("bias outside speed");
	spd_t4_a: assert property (spd |-> terminal4_function inside {0, 3, 6, 9})
		else $error("terminal 4 illegal in speed");
	trq_t4_a: assert property (trq |-> terminal4_function inside {0, 3, 10})
		else $error("terminal 4 illegal in torque");
	pos_t4_a: assert property (pos |-> terminal4_function inside {0, 3, 6})
		else $error("terminal 4 illegal in position");
endmodule

bind control_mode_switch_router mode_router_chk u_chk (.mclk(mclk), .rst_b(rst_b),
	.active_mode(active_mode), .terminal1_function(terminal1_function),
	.terminal4_function(terminal4_function));

// >>> tb/mode_pin_driver.sv
// outside controller model driving the input terminal pins
module mode_pin_driver (
	input  wire        mclk,
	output reg  [11:0] pins,
	output reg         sel_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		pins = 12'h000;
		sel_pin = 1'b0;
	end
	// -------------
	// pin stimulus
	// -------------
	// other pins toggle at random so a wrong terminal pick shows up
	task automatic apply(input int k, input bit msw, input bit asel);
		logic [11:0] v;
		v = 12'($urandom);
		v[k] = msw;
		@(posedge mclk);
		pins <= v;
		sel_pin <= asel;
		repeat (7) @(posedge mclk);
	endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the mode switch router
`include "mode_router_consts.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, rst_b = 0, hsel = 0, hwrite = 0, motor_running = 0;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0]  htrans = 0;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, mode_change_pending, sel_pin;
	wire  [1:0]  active_mode;
	wire  [3:0]  terminal1_function, terminal4_function;
	wire  [11:0] pins;
	int          fails = 0, checks = 0;
	always #5 mclk = ~mclk;
	control_mode_switch_router #(.N_TERM(12)) u_control_mode_switch_router (
		.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .input_terminals(pins),
		.analog_select_input(sel_pin), .motor_running(motor_running),
		.active_mode(active_mode), .terminal1_function(terminal1_function),
		.terminal4_function(terminal4_function), .mode_change_pending(mode_change_pending));
	mode_pin_driver ctl (.mclk(mclk), .pins(pins), .sel_pin(sel_pin));
	// ----------
	// bus tasks
	// ----------
	task automatic close_out;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input [31:0] got, input [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				close_out;
			end
			@(posedge mclk);
		end
	endtask
	task automatic bus(input bit w, input [31:0] a, input [31:0] d, output [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		r = hrdata;
	endtask
	task automatic wr(input [31:0] a, input [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input [31:0] a, input [31:0] exp, input string what);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, exp, what);
		chk(hresp, 32'h0, "bus response");
		chk(hreadyout, 32'h1, "bus ready");
	endtask
	// ---------------
	// reference model
	// ---------------
	function automatic logic [9:0] model(int meth, msw, asel, c1, c4, tl, tc, sl);
		int m, f1, f4;
		case (meth)
			1, 11: m = 1;
			3: m = 2;
			2, 12: m = msw;
			4: m = msw ? 2 : 0;
			5: m = msw ? 1 : 2;
			default: m = 0;
		endcase
		case (c1)
			0: f1 = m == 0 ? 1 : m == 1 ? (meth == 5 ? 1 : 2) : 0;
			1: f1 = 3;
			2: f1 = m != 1 && tl == 1 ? 4 : 0;
			3: f1 = m == 1 && tc == 0 ? 5 : 0;
			4: f1 = m == 1 ? (tc == 0 ? 5 : 0) : (tl == 1 ? 6 : 0);
			5: f1 = m == 1 && sl == 2 ? 7 : 0;
			6: f1 = meth == 4 && m == 0 ? 8 : 0;
			default: f1 = 0;
		endcase
		case (c4)
			0: f4 = !asel ? 0 : m == 0 ? 9 : m == 1 ? 10 : 0;
			1: f4 = 3;
			4: f4 = m != 1 && tl == 1 ? 6 : 0;
			default: f4 = 0;
		endcase
		return {m[1:0], f1[3:0], f4[3:0]};
	endfunction
	// --------
	// sequence
	// --------
	initial begin
		logic [31:0] r;
		logic [9:0]  e;
		int          k, kold, meth, msw, asel, c1, c4, tl, tc, sl;
		int          meths[7] = '{2, 4, 5, 12, 0, 1, 3};
		int          c4s[4] = '{0, 1, 4, 9999};
		r = $urandom(24960);
		kold = 0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		rd(`ADDR_STATUS, 32'h0, "status after reset");
		rd(`ADDR_THRESHOLD, `RST_THRESHOLD, "threshold reset");
		wr(32'h1c, 32'hffff);
		rd(32'h1c, 32'h0, "unmapped read");
		for (int i = 0; i < 200; i++) begin
			meth = meths[$urandom_range(0, 6)];
			c1 = $urandom_range(0, 7);
			c1 = c1 == 7 ? 9999 : c1;
			c4 = c4s[$urandom_range(0, 3)];
			{tl, tc, sl} = {$urandom_range(0, 3), $urandom_range(0, 3), $urandom_range(0, 3)};
			{k, msw, asel} = {$urandom_range(0, 11), $urandom_range(0, 1), $urandom_range(0, 1)};
			wr(`ADDR_METHOD, meth);
			wr(`ADDR_TERM1, c1);
			wr(`ADDR_TERM4, c4);
			wr(`ADDR_SOURCES, tl | tc << 4 | sl << 8);
			wr(32'h20 + 4 * kold, 32'h0);
			wr(32'h20 + 4 * k, `FUNC_CODE_MODE);
			ctl.apply(k, msw, asel);
			e = model(meth, msw, asel, c1, c4, tl, tc, sl);
			chk(active_mode, e[9:8], "mode");
			if (meth inside {2, 4, 5, 12}) begin
				chk(terminal1_function, e[7:4], "terminal 1");
				chk(terminal4_function, e[3:0], "terminal 4");
			end
			kold = k;
		end
		// position changes while running wait for the threshold
		ctl.apply(kold, 0, 0);
		wr(`ADDR_TERM1, 1);
		wr(`ADDR_TERM4, 1);
		wr(`ADDR_METHOD, 2);
		wr(`ADDR_FREQ, 200);
		motor_running <= 1'b1;
		ctl.apply(kold, 1, 0);
		chk(active_mode, `MODE_TORQUE, "switch while running");
		wr(`ADDR_METHOD, 4);
		repeat (6) @(posedge mclk);
		chk(active_mode, `MODE_TORQUE, "deferred change");
		chk(mode_change_pending, 1'b1, "pending set");
		wr(`ADDR_FREQ, 150);
		repeat (6) @(posedge mclk);
		chk(mode_change_pending, 1'b0, "pending clear");
		rd(`ADDR_STATUS, 32'h332, "status in position");
		close_out;
	end
endmodule
